// *** verilog/bmoc_pkg.sv ***
package bmoc_pkg;

    // Operating modes; the host may force all but NORMAL
    typedef enum logic [2:0] {
        BMOC_MODE_NORMAL = 3'b000,
        BMOC_MODE_IDLE = 3'b001,
        BMOC_MODE_LIGHT_SLEEP_STATE = 3'b010,
        BMOC_MODE_SLEEP = 3'b011,
        BMOC_MODE_PDOWN = 3'b100
    } bmoc_mode_e;

    // Balance mode selection
    typedef enum logic [1:0] {
        BMOC_CB_OFF = 2'b00,
        BMOC_CB_CHARGE = 2'b01,
        BMOC_CB_DISCHARGE = 2'b10,
        BMOC_CB_EOC = 2'b11
    } bmoc_cbmode_e;

    // Pack option bits
    typedef struct packed {
        logic fet_temp_on_t2;
        logic fault_shutdown_en;
        logic openwire_shutdown_en;
        logic lockout_pd_en;
        logic openwire_scan_dis;
        logic cascade_en;
    } bmoc_opt_s;

    // Host override bits
    typedef struct packed {
        logic scan;
        logic fet;
        logic chg_mon;
        logic load_mon;
    } bmoc_ovr_s;

    // Host one-shot commands
    typedef struct packed {
        logic force_valid;
        logic [2:0] force_mode;
        logic clear_force;
        logic conv_start;
        logic [3:0] measure_sel;
        logic [1:0] cur_gain;
        logic openwire_start;
        logic clr_chg_err;
        logic clr_load_err;
    } bmoc_cmd_s;

    localparam int MEAS_W = 4;
    localparam int RESULT_W = 14;
    localparam int GAIN_W = 2;
    localparam logic [MEAS_W-1:0] MEAS_SEL_RST = 4'h0;
    localparam logic [GAIN_W-1:0] GAIN_RST = 2'h0;
    localparam logic [6:0] ADDR_LOWER = 7'h28;
    localparam logic [6:0] ADDR_UPPER = 7'h29;
    // Watchdog timeout, figure chosen as plain default
    localparam int WDOG_TIMEOUT_MS = 1;
    localparam int CLK_MHZ = 100;
    localparam int WDOG_CYCLES = WDOG_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int CONV_CYCLES = 16;

endpackage

// *** verilog/bmoc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser for pin inputs; change counts when
// the last two stages agree
module bmoc_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // Shift chain; first stage read only by the second
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Filtered level per bit
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    dout[i] <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    dout[i] <= s3_q[i];
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

// *** verilog/bmoc_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module bmoc_top #(
    parameter int NCELL = 8,
    parameter int WDOG_CYC = bmoc_pkg::WDOG_CYCLES
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire bmoc_pkg::bmoc_opt_s opt,
    input wire bmoc_pkg::bmoc_cbmode_e cb_mode,
    input wire logic position_pin,
    input wire logic t2_overtemp,
    input wire logic cell_overtemp,
    input wire logic cell_fault_flag,
    input wire logic open_wire_det,
    input wire logic supply_lockout_condition,
    input wire logic chg_current,
    input wire logic dis_current,
    input wire logic limits_ok,
    input wire logic [NCELL-1:0] cell_above_eoc,
    input wire logic [NCELL-1:0] cell_above_eoc_hyst,
    input wire logic [NCELL-1:0] cell_above_min_delta,
    input wire logic ovr_set_valid,
    input wire bmoc_pkg::bmoc_ovr_s ovr_set,
    input wire bmoc_pkg::bmoc_cmd_s cmd,
    input wire logic host_fet_chg,
    input wire logic host_fet_dis,
    input wire logic auto_fet_chg,
    input wire logic auto_fet_dis,
    input wire logic pack_shutdown_set,
    input wire logic addr_byte_ok,
    input wire logic [bmoc_pkg::RESULT_W-1:0] adc_data,
    output logic pack_shutdown_output,
    output logic power_down,
    output logic auto_scan_en,
    output logic openwire_scan_go,
    output logic current_sense_en,
    output logic fet_chg,
    output logic fet_dis,
    output logic [NCELL-1:0] balance,
    output logic [6:0] slave_addr,
    output bmoc_pkg::bmoc_mode_e mode,
    output bmoc_pkg::bmoc_ovr_s ovr,
    output logic wdog_expired,
    output logic [bmoc_pkg::MEAS_W-1:0] measure_sel,
    output logic [bmoc_pkg::GAIN_W-1:0] cur_gain,
    output logic conv_busy,
    output logic conv_done,
    output logic [bmoc_pkg::RESULT_W-1:0] conv_result,
    output logic chg_error,
    output logic load_error,
    output logic chg_oc_event_seen
);
    logic rst_s1_q;
    logic rst_n;
    logic pos_q;
    logic [31:0] wd_cnt_q;
    logic any_ovr;
    logic eoc_bal_q;
    logic bal_cond;
    logic pack_current;
    logic [4:0] conv_cnt_q;
    logic [1:0] pin_sync_in;
    logic [1:0] pin_sync;

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // Pin-level inputs cross from outside the clock domain
    assign pin_sync_in = {position_pin, supply_lockout_condition};
    bmoc_sync #(.W(2)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .din(pin_sync_in),
        .dout(pin_sync)
    );
    assign pos_q = pin_sync[1];

    // Role and address from the position pin
    assign slave_addr = pos_q ? bmoc_pkg::ADDR_LOWER
                              : bmoc_pkg::ADDR_UPPER;
    assign current_sense_en = !(opt.cascade_en && pos_q);

    // Override bits; watchdog expiry clears them all
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr <= '0;
        end else if (wdog_expired) begin
            ovr <= '0;
        end else if (ovr_set_valid) begin
            ovr <= ovr_set;
        end
    end
    assign any_ovr = |ovr;

    // Watchdog: runs while any override, restarts on address byte
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt_q <= '0;
        end else if (!any_ovr || addr_byte_ok) begin
            wd_cnt_q <= '0;
        end else if (wd_cnt_q < 32'(WDOG_CYC - 1)) begin
            wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
        end
    end

    // Expiry latch held until a valid address byte arrives
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_expired <= 1'b0;
        end else if (any_ovr && !addr_byte_ok
                     && wd_cnt_q == 32'(WDOG_CYC - 1)) begin
            wdog_expired <= 1'b1;
        end else if (addr_byte_ok) begin
            wdog_expired <= 1'b0;
        end
    end

    // FET drive: expiry off, cascade lower off, host or auto
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fet_chg <= 1'b0;
            fet_dis <= 1'b0;
        end else if (wdog_expired) begin
            fet_chg <= 1'b0;
            fet_dis <= 1'b0;
        end else if (opt.cascade_en && pos_q) begin
            fet_chg <= 1'b0;
            fet_dis <= 1'b0;
        end else if (ovr.fet) begin
            fet_chg <= host_fet_chg;
            fet_dis <= host_fet_dis;
        end else begin
            fet_chg <= auto_fet_chg && !t2_overtemp;
            fet_dis <= auto_fet_dis && !t2_overtemp;
        end
    end

    // Pack shutdown: direct host bit, or enabled fault triggers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pack_shutdown_output <= 1'b0;
        end else if (pack_shutdown_set) begin
            pack_shutdown_output <= 1'b1;
        end else if (opt.fault_shutdown_en && cell_fault_flag) begin
            pack_shutdown_output <= 1'b1;
        end else if (opt.openwire_shutdown_en && open_wire_det) begin
            pack_shutdown_output <= 1'b1;
        end
    end

    // Scan control; overcurrent monitoring is outside and untouched
    assign auto_scan_en = !ovr.scan;
    assign openwire_scan_go = cmd.openwire_start
        || (cell_fault_flag && !opt.openwire_scan_dis && !ovr.scan);

    // Operating mode; only pack current returns to normal
    assign pack_current = chg_current || dis_current;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= bmoc_pkg::BMOC_MODE_NORMAL;
            power_down <= 1'b0;
        end else if (opt.lockout_pd_en && pin_sync[0]) begin
            mode <= bmoc_pkg::BMOC_MODE_PDOWN;
            power_down <= 1'b1;
        end else if (pack_current && !power_down) begin
            mode <= bmoc_pkg::BMOC_MODE_NORMAL;
        end else if (cmd.force_valid) begin
            case (bmoc_pkg::bmoc_mode_e'(cmd.force_mode))
                bmoc_pkg::BMOC_MODE_IDLE,
                bmoc_pkg::BMOC_MODE_LIGHT_SLEEP_STATE,
                bmoc_pkg::BMOC_MODE_SLEEP: begin
                    mode <= bmoc_pkg::bmoc_mode_e'(cmd.force_mode);
                end
                bmoc_pkg::BMOC_MODE_PDOWN: begin
                    mode <= bmoc_pkg::BMOC_MODE_PDOWN;
                    power_down <= 1'b1;
                end
                default: begin
                    mode <= mode;
                end
            endcase
        end
    end

    // End-of-charge balancing hysteresis
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            eoc_bal_q <= 1'b0;
        end else if (|cell_above_eoc) begin
            eoc_bal_q <= 1'b1;
        end else if (!(|cell_above_eoc_hyst)) begin
            eoc_bal_q <= 1'b0;
        end
    end

    // Balance enable by mode; T2 is FET temp when option set
    always_comb begin
        case (cb_mode)
            bmoc_pkg::BMOC_CB_CHARGE: bal_cond = chg_current
                && !dis_current;
            bmoc_pkg::BMOC_CB_DISCHARGE: bal_cond = dis_current
                && !chg_current;
            bmoc_pkg::BMOC_CB_EOC: bal_cond = eoc_bal_q;
            default: bal_cond = 1'b0;
        endcase
        bal_cond = bal_cond && limits_ok && !cell_overtemp
            && (opt.fet_temp_on_t2 || !t2_overtemp)
            && !ovr.scan;
    end

    // Per-cell balance outputs
    genvar c;
    generate
        for (c = 0; c < NCELL; c++) begin : g_cell
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    balance[c] <= 1'b0;
                end else begin
                    balance[c] <= bal_cond && cell_above_min_delta[c];
                end
            end
        end
    endgenerate

    // Single conversion: selection and gain stored, result latched
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            measure_sel <= bmoc_pkg::MEAS_SEL_RST;
            cur_gain <= bmoc_pkg::GAIN_RST;
            conv_cnt_q <= '0;
            conv_busy <= 1'b0;
            conv_done <= 1'b0;
            conv_result <= '0;
        end else begin
            conv_done <= 1'b0;
            if (cmd.conv_start && !conv_busy) begin
                measure_sel <= cmd.measure_sel;
                cur_gain <= cmd.cur_gain;
                conv_busy <= 1'b1;
                conv_cnt_q <= 5'(bmoc_pkg::CONV_CYCLES - 1);
            end else if (conv_busy && conv_cnt_q == 5'h00) begin
                conv_busy <= 1'b0;
                conv_done <= 1'b1;
                conv_result <= adc_data;
            end else if (conv_busy) begin
                conv_cnt_q <= conv_cnt_q - 5'h01;
            end
        end
    end

    // Charger and load error flags; set wins over host clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chg_error <= 1'b0;
            load_error <= 1'b0;
        end else begin
            if (fet_chg == 1'b0 && chg_current && auto_fet_chg) begin
                chg_error <= 1'b1;
            end else if (cmd.clr_chg_err && ovr.chg_mon) begin
                chg_error <= 1'b0;
            end
            if (fet_dis == 1'b0 && dis_current && auto_fet_dis) begin
                load_error <= 1'b1;
            end else if (cmd.clr_load_err && ovr.load_mon) begin
                load_error <= 1'b0;
            end
        end
    end
    assign chg_oc_event_seen = chg_error;

    AST_SHUTDOWN_DIRECT: assert property (@(posedge core_clk)
        disable iff (!rst_n) pack_shutdown_set |=> pack_shutdown_output)
        else $error("shutdown bit did not drive output");
    AST_FAULT_SHUTDOWN: assert property (@(posedge core_clk)
        disable iff (!rst_n) opt.fault_shutdown_en && cell_fault_flag
        |=> pack_shutdown_output)
        else $error("cell fault did not set shutdown");
    AST_OW_SHUTDOWN: assert property (@(posedge core_clk)
        disable iff (!rst_n) opt.openwire_shutdown_en && open_wire_det
        |=> pack_shutdown_output)
        else $error("open wire did not set shutdown");
    AST_WD_FETS_OFF: assert property (@(posedge core_clk)
        disable iff (!rst_n) wdog_expired |=> !fet_chg && !fet_dis)
        else $error("FETs on after watchdog expiry");
    AST_WD_CLEARS_OVR: assert property (@(posedge core_clk)
        disable iff (!rst_n) wdog_expired |=> ovr == '0)
        else $error("override held after expiry");
    AST_CHG_BAL: assert property (@(posedge core_clk)
        disable iff (!rst_n) cb_mode == bmoc_pkg::BMOC_CB_CHARGE
        && !chg_current |=> balance == '0)
        else $error("balanced without charge current");
    AST_DIS_BAL: assert property (@(posedge core_clk)
        disable iff (!rst_n) cb_mode == bmoc_pkg::BMOC_CB_DISCHARGE
        && !dis_current |=> balance == '0)
        else $error("balanced without discharge current");
    AST_CELL_DELTA: assert property (@(posedge core_clk)
        disable iff (!rst_n) balance != '0
        |-> (balance & ~$past(cell_above_min_delta)) == '0)
        else $error("balanced a cell below delta");
    AST_SCAN_OVR: assert property (@(posedge core_clk)
        disable iff (!rst_n) ovr.scan |-> !auto_scan_en ##1 balance == '0)
        else $error("automatic scan or balance while host scans");
    AST_CONV_LEN: assert property (@(posedge core_clk)
        disable iff (!rst_n) cmd.conv_start && !conv_busy
        |=> conv_busy [*8])
        else $error("conversion ended early");
    AST_ADDR: assert property (@(posedge core_clk)
        disable iff (!rst_n) pos_q |-> slave_addr == bmoc_pkg::ADDR_LOWER)
        else $error("wrong address for lower role");

    COV_WD: cover property (@(posedge core_clk) wdog_expired);
    COV_CONV: cover property (@(posedge core_clk) conv_done);
    COV_BAL: cover property (@(posedge core_clk) balance != '0);
    COV_SLEEP: cover property (@(posedge core_clk)
        mode == bmoc_pkg::BMOC_MODE_SLEEP);
endmodule

`default_nettype wire

// *** verification/bmoc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Host controller stand-in; every request is a one-cycle pulse
module bmoc_host_model (
    input wire logic core_clk,
    output logic ovr_set_valid,
    output bmoc_pkg::bmoc_ovr_s ovr_set,
    output bmoc_pkg::bmoc_cmd_s cmd,
    output logic addr_byte_ok
);
    // Idle levels at time zero
    initial begin
        ovr_set_valid = 1'b0;
        ovr_set = '0;
        cmd = '0;
        addr_byte_ok = 1'b0;
    end

    // Override load; data flips after the strobe so stale bits show
    task automatic set_ovr(input bmoc_pkg::bmoc_ovr_s v);
        @(posedge core_clk);
        ovr_set <= v;
        ovr_set_valid <= 1'b1;
        @(posedge core_clk);
        ovr_set_valid <= 1'b0;
        ovr_set <= ~v;
    endtask

    // Mode force, conversion start, gain, error clears
    task automatic send_cmd(input bmoc_pkg::bmoc_cmd_s c);
        @(posedge core_clk);
        cmd <= c;
        @(posedge core_clk);
        cmd <= '0;
    endtask

    // Valid slave address byte seen on the link
    task automatic ping();
        @(posedge core_clk);
        addr_byte_ok <= 1'b1;
        @(posedge core_clk);
        addr_byte_ok <= 1'b0;
    endtask
endmodule

`default_nettype wire

// *** verification/bmoc_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module bmoc_top_test;
    localparam int WD = 20;
    logic core_clk = 1'b0, resetn = 1'b0, position_pin = 1'b0;
    logic t2_overtemp = 1'b0, cell_overtemp = 1'b0;
    logic cell_fault_flag = 1'b0, open_wire_det = 1'b0;
    logic supply_lockout_condition = 1'b0, limits_ok = 1'b1;
    logic chg_current = 1'b0, dis_current = 1'b0;
    logic host_fet_chg = 1'b0, host_fet_dis = 1'b0;
    logic auto_fet_chg = 1'b0, auto_fet_dis = 1'b0;
    logic pack_shutdown_set = 1'b0;
    logic [7:0] cell_above_eoc = 8'h00, cell_above_eoc_hyst = 8'h00;
    logic [7:0] cell_above_min_delta = 8'hA5;
    logic [13:0] adc_data = 14'h2ABC;
    bmoc_pkg::bmoc_opt_s opt = '0;
    bmoc_pkg::bmoc_cbmode_e cb_mode = bmoc_pkg::BMOC_CB_OFF;
    bmoc_pkg::bmoc_ovr_s ovr_set, ovr;
    bmoc_pkg::bmoc_cmd_s cmd, c;
    bmoc_pkg::bmoc_mode_e mode;
    logic ovr_set_valid, addr_byte_ok, pack_shutdown_output, power_down;
    logic auto_scan_en, openwire_scan_go, current_sense_en, fet_chg;
    logic fet_dis, wdog_expired, conv_busy, conv_done, chg_error;
    logic load_error, chg_oc_event_seen;
    logic [7:0] balance;
    logic [6:0] slave_addr;
    logic [3:0] measure_sel;
    logic [1:0] cur_gain;
    logic [13:0] conv_result;
    int fail_count = 0, compares = 0, n;
    // Balance table: mode, {discharge, charge}, balancing expected
    bmoc_pkg::bmoc_cbmode_e tm[6] = '{bmoc_pkg::BMOC_CB_CHARGE,
        bmoc_pkg::BMOC_CB_CHARGE, bmoc_pkg::BMOC_CB_CHARGE,
        bmoc_pkg::BMOC_CB_DISCHARGE, bmoc_pkg::BMOC_CB_DISCHARGE,
        bmoc_pkg::BMOC_CB_OFF};
    logic [1:0] tc[6] = '{2'h1, 2'h2, 2'h0, 2'h2, 2'h1, 2'h1};
    logic te[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    // End-of-charge steps: above threshold, above hysteresis, expected
    logic [7:0] ev[4] = '{8'h00, 8'h10, 8'h00, 8'h00};
    logic [7:0] hv[4] = '{8'h00, 8'h00, 8'h10, 8'h00};
    logic ee[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    bmoc_host_model host (.core_clk, .ovr_set_valid, .ovr_set, .cmd,
        .addr_byte_ok);

    bmoc_top #(.NCELL(8), .WDOG_CYC(WD)) dut (.core_clk, .resetn, .opt,
        .cb_mode, .position_pin, .t2_overtemp, .cell_overtemp,
        .cell_fault_flag, .open_wire_det, .supply_lockout_condition,
        .chg_current, .dis_current, .limits_ok, .cell_above_eoc,
        .cell_above_eoc_hyst, .cell_above_min_delta, .ovr_set_valid,
        .ovr_set, .cmd, .host_fet_chg, .host_fet_dis, .auto_fet_chg,
        .auto_fet_dis, .pack_shutdown_set, .addr_byte_ok, .adc_data,
        .pack_shutdown_output, .power_down, .auto_scan_en,
        .openwire_scan_go, .current_sense_en, .fet_chg, .fet_dis,
        .balance, .slave_addr, .mode, .ovr, .wdog_expired, .measure_sel,
        .cur_gain, .conv_busy, .conv_done, .conv_result, .chg_error,
        .load_error, .chg_oc_event_seen);

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Wait k edges, then step past them so outputs have settled
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    // Shutdown and power-down stick, so scenarios restart from here
    task automatic do_reset();
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        tick(4);
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        chk("ovr", 32'h0, ovr);
        chk("mode", bmoc_pkg::BMOC_MODE_NORMAL, mode);
        $display("test reset done");
        // Shutdown sources gated by their enables
        for (int i = 0; i < 2; i++) begin
            // Enables off before reset, so release sets nothing sticky
            @(posedge core_clk);
            opt <= '0;
            cell_fault_flag <= (i == 0);
            open_wire_det <= (i == 1);
            do_reset();
            tick(3);
            chk("shutdown_off", 32'h0, pack_shutdown_output);
            @(posedge core_clk);
            opt.fault_shutdown_en <= 1'b1;
            opt.openwire_shutdown_en <= 1'b1;
            tick(3);
            chk("shutdown_on", 32'h1, pack_shutdown_output);
        end
        @(posedge core_clk);
        opt <= '0;
        cell_fault_flag <= 1'b0;
        open_wire_det <= 1'b0;
        do_reset();
        @(posedge core_clk);
        pack_shutdown_set <= 1'b1;
        tick(3);
        chk("shutdown_direct", 32'h1, pack_shutdown_output);
        $display("test shutdown done");
        // Open-wire scan: disabled on fault, manual start immediate
        @(posedge core_clk);
        pack_shutdown_set <= 1'b0;
        opt.openwire_scan_dis <= 1'b1;
        cell_fault_flag <= 1'b1;
        tick(3);
        chk("ow_dis", 32'h0, openwire_scan_go);
        @(posedge core_clk);
        opt.openwire_scan_dis <= 1'b0;
        cell_fault_flag <= 1'b0;
        c = '0;
        c.openwire_start = 1'b1;
        // Start is a one-cycle pulse, so look while it stands
        fork
            host.send_cmd(c);
            begin
                tick(1);
                chk("ow_start", 32'h1, openwire_scan_go);
            end
        join
        $display("test open wire done");
        // Cascade role and address from the position pin
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            opt.cascade_en <= 1'b1;
            position_pin <= (i == 0);
            auto_fet_chg <= 1'b1;
            tick(6);
            chk("sense", i, current_sense_en);
            chk("fet_role", i, fet_chg);
            chk("addr", i ? bmoc_pkg::ADDR_UPPER : bmoc_pkg::ADDR_LOWER,
                slave_addr);
        end
        // FETs follow host only under its override
        host.set_ovr(4'h4);
        tick(2);
        chk("fet_host0", 32'h0, fet_chg);
        @(posedge core_clk);
        host_fet_chg <= 1'b1;
        auto_fet_chg <= 1'b0;
        tick(2);
        chk("fet_host1", 32'h1, fet_chg);
        host.set_ovr(4'h0);
        @(posedge core_clk);
        auto_fet_chg <= 1'b1;
        host_fet_chg <= 1'b0;
        $display("test cascade and fets done");
        // Balance by mode and current direction
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            cb_mode <= tm[i];
            {dis_current, chg_current} <= tc[i];
            tick(3);
            chk("bal", te[i] ? 8'hA5 : 8'h00, balance);
        end
        @(posedge core_clk);
        cb_mode <= bmoc_pkg::BMOC_CB_EOC;
        {dis_current, chg_current} <= 2'h2;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            cell_above_eoc <= ev[i];
            cell_above_eoc_hyst <= hv[i];
            tick(3);
            chk("bal_eoc", ee[i] ? 8'hA5 : 8'h00, balance);
        end
        // Second thermal input as FET sensor spares balancing
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            cb_mode <= bmoc_pkg::BMOC_CB_CHARGE;
            {dis_current, chg_current} <= 2'h1;
            t2_overtemp <= 1'b1;
            opt.fet_temp_on_t2 <= (i == 1);
            tick(3);
            chk("bal_t2", i ? 8'hA5 : 8'h00, balance);
        end
        chk("fet_t2", 32'h0, fet_chg);
        $display("test balance done");
        // Forced modes without any override; only current restores
        @(posedge core_clk);
        t2_overtemp <= 1'b0;
        {dis_current, chg_current} <= 2'h0;
        c = '0;
        c.force_valid = 1'b1;
        for (int m = 1; m < 5; m++) begin
            c.force_mode = (m == 4) ? 3'h0 : m[2:0];
            host.send_cmd(c);
            tick(2);
            chk("mode", (m == 4) ? 3'h3 : m, mode);
        end
        @(posedge core_clk);
        chg_current <= 1'b1;
        tick(3);
        chk("mode_cur", bmoc_pkg::BMOC_MODE_NORMAL, mode);
        @(posedge core_clk);
        chg_current <= 1'b0;
        $display("test modes done");
        // Single conversion with host gain
        c = '0;
        c.conv_start = 1'b1;
        c.measure_sel = 4'h9;
        c.cur_gain = 2'h3;
        host.send_cmd(c);
        #1;
        chk("sel", 32'h9, measure_sel);
        chk("gain", 32'h3, cur_gain);
        chk("busy", 32'h1, conv_busy);
        for (n = 2; n < 40 && conv_done !== 1'b1; n++) tick(1);
        chk("conv_cyc", 32'd17, n - 1);
        if (n == 40) end_sim();
        chk("result", 14'h2ABC, conv_result);
        $display("test conversion done");
        // Watchdog kept alive by address bytes, then left to expire
        chk("scan_auto", 32'h1, auto_scan_en);
        @(posedge core_clk);
        host_fet_chg <= 1'b1;
        host_fet_dis <= 1'b1;
        host.set_ovr(4'hC);
        tick(1);
        chk("scan_host", 32'h0, auto_scan_en);
        repeat (4) begin
            tick(12);
            host.ping();
        end
        #1;
        chk("wd_alive", 32'hC, {wdog_expired, ovr});
        for (n = 0; n < 30 && wdog_expired !== 1'b1; n++) tick(1);
        if (n == 30) begin
            chk("wd_wait", 32'h1, wdog_expired);
            end_sim();
        end
        tick(1);
        chk("wd_ovr", 32'h0, ovr);
        chk("wd_fets", 32'h0, {fet_chg, fet_dis});
        $display("test watchdog done");
        // Monitor overrides: host clears charge then load error
        for (int i = 0; i < 2; i++) begin
            host.ping();
            @(posedge core_clk);
            host_fet_chg <= 1'b0;
            host_fet_dis <= 1'b0;
            auto_fet_dis <= 1'b1;
            {dis_current, chg_current} <= i ? 2'h2 : 2'h1;
            host.set_ovr(i ? 4'h5 : 4'h6);
            tick(3);
            chk("err_set", 32'h1, i ? load_error : chg_error);
            @(posedge core_clk);
            {dis_current, chg_current} <= 2'h0;
            c = '0;
            c.clr_chg_err = (i == 0);
            c.clr_load_err = (i == 1);
            host.send_cmd(c);
            tick(2);
            chk("err_clr", 32'h0, i ? load_error : chg_error);
        end
        chk("oc_seen", 32'h0, chg_oc_event_seen);
        host.set_ovr(4'h0);
        $display("test monitors done");
        // Lockout power-down only when enabled
        @(posedge core_clk);
        supply_lockout_condition <= 1'b1;
        tick(8);
        chk("pd_off", 32'h0, power_down);
        @(posedge core_clk);
        opt.lockout_pd_en <= 1'b1;
        tick(3);
        chk("pd_on", 32'h1, power_down);
        // Forced power-down holds even against pack current
        @(posedge core_clk);
        supply_lockout_condition <= 1'b0;
        opt.lockout_pd_en <= 1'b0;
        do_reset();
        c = '0;
        c.force_valid = 1'b1;
        c.force_mode = 3'h4;
        host.send_cmd(c);
        @(posedge core_clk);
        chg_current <= 1'b1;
        tick(3);
        chk("pd_force", 32'h9, {mode, power_down});
        $display("test lockout done");
        end_sim();
    end
endmodule

`default_nettype wire
